// ==== iod_map.svh ====
// Address map, field masks and limits of the I/O register space decoder
// Operation
// - Bit set and clear reach I/O addresses 0x00 to 0x1F, one bit each.
// - Skip-if-bit instructions test one bit of the lowest 32 I/O locations.
// - Writing one clears a status flag; writing zero leaves it unchanged.
// - Bit set or clear never clears other flags of the same register.
// - Dedicated I/O instructions address 0x00 to 0x3F, 64 locations.
// - As data memory each lower I/O register sits at I/O address plus 0x20.
// - Data address 0x60 is reachable only by load and store; 0x61 to 0xFF are refused.
// - EEPROM address bits above the top implemented bit are ignored.
`ifndef IOD_MAP_SVH
`define IOD_MAP_SVH
`define IOD_BANK_BASE 8'h20
`define IOD_BANK_TOP 8'h60
`define IOD_ALIAS_OFFSET 8'h20
`define IOD_IO_TOP 8'h3F
`define IOD_BIT_TOP 8'h1F
`define IOD_REG_COUNT 65
`define IOD_IMAGE_W 520
`define IOD_EE_TOP_BIT_DEF 8
`define IOD_PORT_A_INPUT_PINS 8'h20
`define IOD_PORT_A_DIRECTION 8'h21
`define IOD_PORT_A_OUTPUT_LATCH 8'h22
`define IOD_PORT_B_INPUT_PINS 8'h23
`define IOD_PORT_B_DIRECTION 8'h24
`define IOD_PORT_B_OUTPUT_LATCH 8'h25
`define IOD_PORT_PULLUP_BREAKBEFORE_CTRL 8'h32
`define IOD_TIMER0_FLAGS 8'h35
`define IOD_TIMER1_FLAGS 8'h36
`define IOD_PIN_CHANGE_FLAGS 8'h3B
`define IOD_EXTERNAL_IRQ_FLAGS 8'h3C
`define IOD_EXTERNAL_IRQ_MASK 8'h3D
`define IOD_GENERAL_PURPOSE_0 8'h3E
`define IOD_EEPROM_CONTROL 8'h3F
`define IOD_EEPROM_DATA 8'h40
`define IOD_EEPROM_ADDRESS_LOW 8'h41
`define IOD_EEPROM_ADDRESS_HIGH 8'h42
`define IOD_TIMER_PRESCALER_SYNC_CTRL 8'h43
`define IOD_TIMER0_CONTROL_A 8'h45
`define IOD_TIMER0_CONTROL_B 8'h46
`define IOD_TIMER0_COUNT 8'h47
`define IOD_TIMER0_COMPARE_A 8'h48
`define IOD_GENERAL_PURPOSE_1 8'h4A
`define IOD_GENERAL_PURPOSE_2 8'h4B
`define IOD_SERIAL_PORT_CONTROL 8'h4C
`define IOD_SERIAL_PORT_STATUS 8'h4D
`define IOD_SERIAL_PORT_DATA 8'h4E
`define IOD_COMPARATOR_CONTROL_STATUS 8'h50
`define IOD_DEBUG_WIRE_DATA 8'h51
`define IOD_SLEEP_MODE_CONTROL 8'h53
`define IOD_RESET_CAUSE_FLAGS 8'h54
`define IOD_CORE_MISC_CONTROL 8'h55
`define IOD_SELF_PROGRAM_CTRL_STATUS 8'h57
`define IOD_STACK_POINTER_LOW 8'h5D
`define IOD_STACK_POINTER_HIGH 8'h5E
`define IOD_CORE_STATUS_FLAGS 8'h5F
`define IOD_WATCHDOG_CONTROL 8'h60
`define IOD_M_FULL 8'hFF
`define IOD_M_NONE 8'h00
`define IOD_M_PORT_PULLUP_BREAKBEFORE_CTRL 8'h33
`define IOD_M_LOW2 8'h03
`define IOD_M_TIMER1_FLAGS 8'h27
`define IOD_M_EEPROM_CONTROL 8'h3F
`define IOD_M_EEPROM_ADDRESS_HIGH 8'h01
`define IOD_M_TIMER_PRESCALER_SYNC_CTRL 8'h83
`define IOD_M_TIMER0_CONTROL_A 8'hC3
`define IOD_M_TIMER0_CONTROL_B 8'h87
`define IOD_M_SERIAL_PORT_STATUS_RW 8'h01
`define IOD_M_SERIAL_PORT_STATUS_RO 8'hC0
`define IOD_M_COMPARATOR_CONTROL_STATUS_RW 8'hCF
`define IOD_M_COMPARATOR_CONTROL_STATUS_RO 8'h20
`define IOD_M_COMPARATOR_CONTROL_STATUS_W1C 8'h10
`define IOD_M_SLEEP_MODE_CONTROL 8'h07
`define IOD_M_RESET_CAUSE_FLAGS 8'h0F
`define IOD_M_CORE_MISC_CONTROL 8'h70
`define IOD_M_SELF_PROGRAM_CTRL_STATUS_RW 8'h3F
`define IOD_M_SELF_PROGRAM_CTRL_STATUS_RO 8'h40
`define IOD_M_WDT_RW 8'h7F
`define IOD_M_WDT_W1C 8'h80
`endif

// ==== iod_pkg.sv ====
// Types shared by the I/O register space decoder
package iod_pkg;
	typedef enum logic [2:0] {
		io_read_instr,
		io_write_instr,
		data_load_instrs,
		data_store_instrs,
		io_bit_set_instr,
		io_bit_clear_instr,
		skip_if_io_bit_set_instr,
		skip_if_io_bit_clear_instr
	} iod_op_type;
endpackage : iod_pkg

// ==== iod_io_space_decoder.sv ====
// I/O register space decoder with bit access, alias and write-one-to-clear flags
`timescale 1ns/10ps
`default_nettype none
`include "iod_map.svh"
module iod_io_space_decoder #(
	parameter int EE_TOP_BIT = `IOD_EE_TOP_BIT_DEF
) (
	input  wire logic                     clk,
	input  wire logic                     reset_n,
	input  wire logic                     req,
	input  wire iod_pkg::iod_op_type      op,
	input  wire logic [7:0]               addr,
	input  wire logic [7:0]               wdata,
	input  wire logic [2:0]               bit_sel,
	input  wire logic [`IOD_IMAGE_W-1:0]  hw_set_flat,
	input  wire logic [`IOD_IMAGE_W-1:0]  hw_status_flat,
	output logic                          ack_q,
	output logic                          err_q,
	output logic                          skip_q,
	output logic [7:0]                    rdata_q,
	output logic [`IOD_IMAGE_W-1:0]       reg_image_q,
	output logic [15:0]                   eeprom_sel_addr_q
);
	localparam int N = `IOD_REG_COUNT;
	localparam logic [15:0] EE_MASK = 16'((32'd1 << (EE_TOP_BIT + 1)) - 1);

	// Software-writable bits; apart from write-one-to-clear flags everything else stays zero
	function automatic logic [7:0] rw_mask(input logic [7:0] a);
		case (a)
			`IOD_PORT_A_DIRECTION, `IOD_PORT_A_OUTPUT_LATCH,
			`IOD_PORT_B_DIRECTION, `IOD_PORT_B_OUTPUT_LATCH,
			`IOD_GENERAL_PURPOSE_0, `IOD_EEPROM_DATA,
			`IOD_EEPROM_ADDRESS_LOW, `IOD_TIMER0_COUNT,
			`IOD_TIMER0_COMPARE_A, `IOD_GENERAL_PURPOSE_1,
			`IOD_GENERAL_PURPOSE_2, `IOD_SERIAL_PORT_CONTROL,
			`IOD_SERIAL_PORT_DATA, `IOD_DEBUG_WIRE_DATA,
			`IOD_STACK_POINTER_LOW, `IOD_STACK_POINTER_HIGH,
			`IOD_CORE_STATUS_FLAGS: rw_mask = `IOD_M_FULL;
			`IOD_PORT_PULLUP_BREAKBEFORE_CTRL: rw_mask = `IOD_M_PORT_PULLUP_BREAKBEFORE_CTRL;
			`IOD_EXTERNAL_IRQ_MASK: rw_mask = `IOD_M_LOW2;
			`IOD_EEPROM_CONTROL: rw_mask = `IOD_M_EEPROM_CONTROL;
			`IOD_EEPROM_ADDRESS_HIGH: rw_mask = `IOD_M_EEPROM_ADDRESS_HIGH;
			`IOD_TIMER_PRESCALER_SYNC_CTRL: rw_mask = `IOD_M_TIMER_PRESCALER_SYNC_CTRL;
			`IOD_TIMER0_CONTROL_A: rw_mask = `IOD_M_TIMER0_CONTROL_A;
			`IOD_TIMER0_CONTROL_B: rw_mask = `IOD_M_TIMER0_CONTROL_B;
			`IOD_SERIAL_PORT_STATUS: rw_mask = `IOD_M_SERIAL_PORT_STATUS_RW;
			`IOD_COMPARATOR_CONTROL_STATUS: rw_mask = `IOD_M_COMPARATOR_CONTROL_STATUS_RW;
			`IOD_SLEEP_MODE_CONTROL: rw_mask = `IOD_M_SLEEP_MODE_CONTROL;
			`IOD_RESET_CAUSE_FLAGS: rw_mask = `IOD_M_RESET_CAUSE_FLAGS;
			`IOD_CORE_MISC_CONTROL: rw_mask = `IOD_M_CORE_MISC_CONTROL;
			`IOD_SELF_PROGRAM_CTRL_STATUS: rw_mask = `IOD_M_SELF_PROGRAM_CTRL_STATUS_RW;
			`IOD_WATCHDOG_CONTROL: rw_mask = `IOD_M_WDT_RW;
			default: rw_mask = `IOD_M_NONE;
		endcase
	endfunction : rw_mask

	// Flags cleared by writing one
	function automatic logic [7:0] w1c_mask(input logic [7:0] a);
		case (a)
			`IOD_TIMER0_FLAGS, `IOD_PIN_CHANGE_FLAGS,
			`IOD_EXTERNAL_IRQ_FLAGS: w1c_mask = `IOD_M_LOW2;
			`IOD_TIMER1_FLAGS: w1c_mask = `IOD_M_TIMER1_FLAGS;
			`IOD_COMPARATOR_CONTROL_STATUS: w1c_mask = `IOD_M_COMPARATOR_CONTROL_STATUS_W1C;
			`IOD_WATCHDOG_CONTROL: w1c_mask = `IOD_M_WDT_W1C;
			default: w1c_mask = `IOD_M_NONE;
		endcase
	endfunction : w1c_mask

	// Bits that show live peripheral state, never stored here
	function automatic logic [7:0] ro_mask(input logic [7:0] a);
		case (a)
			`IOD_PORT_A_INPUT_PINS,
			`IOD_PORT_B_INPUT_PINS: ro_mask = `IOD_M_FULL;
			`IOD_SERIAL_PORT_STATUS: ro_mask = `IOD_M_SERIAL_PORT_STATUS_RO;
			`IOD_COMPARATOR_CONTROL_STATUS: ro_mask = `IOD_M_COMPARATOR_CONTROL_STATUS_RO;
			`IOD_SELF_PROGRAM_CTRL_STATUS: ro_mask = `IOD_M_SELF_PROGRAM_CTRL_STATUS_RO;
			default: ro_mask = `IOD_M_NONE;
		endcase
	endfunction : ro_mask

	logic       is_io;
	logic       is_bit;
	logic       is_wr;
	logic       is_skip;
	logic       form_ok;
	logic       in_bank;
	logic       hit;
	logic       wr_go;
	logic [7:0] daddr;
	logic [6:0] idx;
	logic [7:0] en;
	logic [7:0] wval;
	logic [7:0] cur_view;
	logic [7:0] cur_rw;
	logic [7:0] cur_w1;
	logic [7:0] reg_view [N];
	logic [`IOD_IMAGE_W-1:0] img_d;

	// Request decode
	always_comb begin
		is_skip = (op == iod_pkg::skip_if_io_bit_set_instr) ||
			(op == iod_pkg::skip_if_io_bit_clear_instr);
		is_bit = is_skip || (op == iod_pkg::io_bit_set_instr) ||
			(op == iod_pkg::io_bit_clear_instr);
		is_io = is_bit || (op == iod_pkg::io_read_instr) ||
			(op == iod_pkg::io_write_instr);
		is_wr = (op == iod_pkg::io_write_instr) ||
			(op == iod_pkg::data_store_instrs) ||
			(op == iod_pkg::io_bit_set_instr) ||
			(op == iod_pkg::io_bit_clear_instr);
		// I/O forms land on the data-space alias
		daddr = is_io ? 8'(addr + `IOD_ALIAS_OFFSET) : addr;
		if (is_bit) begin
			form_ok = addr <= `IOD_BIT_TOP;
		end else if (is_io) begin
			form_ok = addr <= `IOD_IO_TOP;
		end else begin
			form_ok = 1'b1;
		end
		in_bank = (daddr >= `IOD_BANK_BASE) && (daddr <= `IOD_BANK_TOP);
		hit = req && form_ok && in_bank;
		wr_go = hit && is_wr;
		idx = 7'(daddr - `IOD_BANK_BASE);
		// One-hot enable keeps neighbouring flags safe
		en = is_bit ? 8'(8'h01 << bit_sel) : `IOD_M_FULL;
		if (op == iod_pkg::io_bit_set_instr) begin
			wval = `IOD_M_FULL;
		end else if (op == iod_pkg::io_bit_clear_instr) begin
			wval = `IOD_M_NONE;
		end else begin
			wval = wdata;
		end
		cur_view = hit ? reg_view[idx] : `IOD_M_NONE;
		cur_rw = rw_mask(daddr);
		cur_w1 = w1c_mask(daddr);
	end

	// Reserved bits read zero
	for (genvar g = 0; g < N; g++) begin : g_view
		localparam logic [7:0] A = 8'(`IOD_BANK_BASE + g);
		assign reg_view[g] = (reg_image_q[g*8 +: 8] & (rw_mask(A) | w1c_mask(A)))
			| (hw_status_flat[g*8 +: 8] & ro_mask(A));
	end

	// Next state of the stored bits; a hardware set wins over a clear
	always_comb begin
		logic [7:0] a;
		logic [7:0] m_rw;
		logic [7:0] m_w1;
		logic [7:0] nxt;
		a = `IOD_M_NONE;
		m_rw = `IOD_M_NONE;
		m_w1 = `IOD_M_NONE;
		nxt = `IOD_M_NONE;
		img_d = reg_image_q;
		for (int i = 0; i < N; i++) begin
			a = 8'(`IOD_BANK_BASE + i);
			m_rw = rw_mask(a);
			m_w1 = w1c_mask(a);
			nxt = reg_image_q[i*8 +: 8];
			if (wr_go && idx == 7'(i)) begin
				nxt = (nxt & ~(en & m_rw)) | (wval & en & m_rw);
				nxt = nxt & ~(en & wval & m_w1);
			end
			nxt = nxt | (hw_set_flat[i*8 +: 8] & (m_rw | m_w1));
			img_d[i*8 +: 8] = nxt;
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			reg_image_q <= '0;
		end else begin
			reg_image_q <= img_d;
		end
	end

	// Answer one cycle after the request
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			ack_q <= 1'b0;
			err_q <= 1'b0;
			skip_q <= 1'b0;
			rdata_q <= `IOD_M_NONE;
		end else begin
			ack_q <= req;
			err_q <= req && !(form_ok && in_bank);
			skip_q <= hit && is_skip && (cur_view[bit_sel] ==
				(op == iod_pkg::skip_if_io_bit_set_instr));
			rdata_q <= (hit && !is_wr && !is_bit) ? cur_view : `IOD_M_NONE;
		end
	end

	// Only implemented address bits select the EEPROM cell
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			eeprom_sel_addr_q <= 16'h0000;
		end else begin
			eeprom_sel_addr_q <= {reg_view[7'(`IOD_EEPROM_ADDRESS_HIGH - `IOD_BANK_BASE)],
				reg_view[7'(`IOD_EEPROM_ADDRESS_LOW - `IOD_BANK_BASE)]} & EE_MASK;
		end
	end

	// Checks
	logic [7:0] hw_at_idx;
	logic [7:0] img_at_idx;
	localparam logic [6:0] WDT_IDX = 7'(`IOD_WATCHDOG_CONTROL - `IOD_BANK_BASE);
	assign hw_at_idx = hit ? hw_set_flat[idx*8 +: 8] : `IOD_M_NONE;
	assign img_at_idx = hit ? reg_image_q[idx*8 +: 8] : `IOD_M_NONE;
	logic [7:0]              hw_keep;
	logic [`IOD_IMAGE_W-1:0] store_mask;
	localparam logic [6:0] EEL_IDX = 7'(`IOD_EEPROM_ADDRESS_LOW - `IOD_BANK_BASE);
	localparam logic [6:0] EEH_IDX = 7'(`IOD_EEPROM_ADDRESS_HIGH - `IOD_BANK_BASE);
	// Hardware sets on stored bits of the addressed byte
	assign hw_keep = hw_at_idx & (cur_rw | cur_w1);

	// Stored bits per location; anything outside must stay zero
	for (genvar k = 0; k < N; k++) begin : g_store
		localparam logic [7:0] SA = 8'(`IOD_BANK_BASE + k);
		assign store_mask[k*8 +: 8] = rw_mask(SA) | w1c_mask(SA);
	end

	sequence s_bit_set_go;
		hit && op == iod_pkg::io_bit_set_instr && cur_rw[bit_sel];
	endsequence
	property p_bit_set;
		@(posedge clk) disable iff (!reset_n)
		s_bit_set_go |=> reg_image_q[$past(idx)*8 + $past(bit_sel)];
	endproperty
	a_bit_set: assert property (p_bit_set) else $error("bit set lost");

	property p_skip;
		@(posedge clk) disable iff (!reset_n)
		(hit && is_skip) |=> ack_q && (skip_q == ($past(cur_view[bit_sel]) ==
			$past(op == iod_pkg::skip_if_io_bit_set_instr)));
	endproperty
	a_skip: assert property (p_skip) else $error("skip result wrong");

	property p_w1c;
		@(posedge clk) disable iff (!reset_n)
		(wr_go && !is_bit && hw_at_idx == 8'h00) |=>
			(reg_image_q[$past(idx)*8 +: 8] & $past(cur_w1)) ==
			($past(img_at_idx) & ~$past(wval) & $past(cur_w1));
	endproperty
	a_w1c: assert property (p_w1c) else $error("flag clear wrong");

	property p_bit_only;
		@(posedge clk) disable iff (!reset_n)
		(wr_go && is_bit && hw_at_idx == 8'h00) |=>
			(reg_image_q[$past(idx)*8 +: 8] & ~$past(en)) ==
			($past(img_at_idx) & ~$past(en));
	endproperty
	a_bit_only: assert property (p_bit_only) else $error("other bit changed");

	property p_io_range;
		@(posedge clk) disable iff (!reset_n)
		(req && is_io && !is_bit) |=> ack_q && err_q == $past(addr > `IOD_IO_TOP);
	endproperty
	a_io_range: assert property (p_io_range) else $error("io range wrong");

	property p_alias;
		@(posedge clk) disable iff (!reset_n)
		(req && op == iod_pkg::io_read_instr && addr <= `IOD_IO_TOP) |=>
			rdata_q == $past(reg_view[7'(addr)]);
	endproperty
	a_alias: assert property (p_alias) else $error("alias read wrong");

	property p_ext_io;
		@(posedge clk) disable iff (!reset_n)
		(req && is_io && hw_set_flat[WDT_IDX*8 +: 8] == 8'h00) |=>
			$stable(reg_image_q[WDT_IDX*8 +: 8]);
	endproperty
	a_ext_io: assert property (p_ext_io) else $error("io form hit extended");

	property p_ee_mask;
		@(posedge clk) disable iff (!reset_n)
		1'b1 |=> eeprom_sel_addr_q == ($past({reg_image_q[EEH_IDX*8 +: 8],
			reg_image_q[EEL_IDX*8 +: 8]}) & EE_MASK);
	endproperty
	a_ee_mask: assert property (p_ee_mask) else $error("eeprom high bits used");

	property p_reserved;
		@(posedge clk) disable iff (!reset_n)
		(hit && op == iod_pkg::data_load_instrs &&
			(rw_mask(daddr) | w1c_mask(daddr) | ro_mask(daddr)) == 8'h00) |=>
			ack_q && rdata_q == 8'h00;
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved read nonzero");

	// Request, refusal and idle cycle seen from the core
	sequence s_request;
		req;
	endsequence
	sequence s_refused;
		req && !(form_ok && in_bank);
	endsequence
	sequence s_idle;
		!req;
	endsequence
	sequence s_plain_write;
		req && op == iod_pkg::io_write_instr && form_ok && cur_w1 == 8'h00 &&
			hw_at_idx == 8'h00;
	endsequence

	property p_ack;
		@(posedge clk) disable iff (!reset_n)
		s_request |=> ack_q;
	endproperty
	a_ack: assert property (p_ack) else $error("request not answered");

	property p_idle;
		@(posedge clk) disable iff (!reset_n)
		s_idle |=> !ack_q && !err_q && !skip_q && rdata_q == 8'h00;
	endproperty
	a_idle: assert property (p_idle) else $error("answer without request");

	property p_refused;
		@(posedge clk) disable iff (!reset_n)
		s_refused |=> ack_q && err_q && !skip_q && rdata_q == 8'h00;
	endproperty
	a_refused: assert property (p_refused) else $error("refusal answer wrong");

	property p_refused_quiet;
		@(posedge clk) disable iff (!reset_n)
		(s_refused ##0 (hw_set_flat == '0)) |=> $stable(reg_image_q);
	endproperty
	a_refused_quiet: assert property (p_refused_quiet) else $error("refused write landed");

	property p_skip_only;
		@(posedge clk) disable iff (!reset_n)
		!(req && is_skip) |=> !skip_q;
	endproperty
	a_skip_only: assert property (p_skip_only) else $error("skip without test");

	property p_bit_range;
		@(posedge clk) disable iff (!reset_n)
		(req && is_bit) |=> rdata_q == 8'h00 &&
			err_q == $past(addr > `IOD_BIT_TOP);
	endproperty
	a_bit_range: assert property (p_bit_range) else $error("bit range wrong");

	// A clear that meets a new hardware event must not lose the event
	property p_set_wins;
		@(posedge clk) disable iff (!reset_n)
		(wr_go && hw_keep != 8'h00) |=>
			(reg_image_q[$past(idx)*8 +: 8] & $past(hw_keep)) == $past(hw_keep);
	endproperty
	a_set_wins: assert property (p_set_wins) else $error("hardware set lost");

	property p_alias_write;
		@(posedge clk) disable iff (!reset_n)
		s_plain_write |=> reg_image_q[$past(addr)*8 +: 8] == $past(wdata & cur_rw);
	endproperty
	a_alias_write: assert property (p_alias_write) else $error("alias write wrong");

	property p_ext_load;
		@(posedge clk) disable iff (!reset_n)
		(hit && op == iod_pkg::data_load_instrs && daddr == `IOD_WATCHDOG_CONTROL) |=>
			rdata_q == $past(reg_image_q[WDT_IDX*8 +: 8]);
	endproperty
	a_ext_load: assert property (p_ext_load) else $error("extended load wrong");

	property p_reserved_bits;
		@(posedge clk) disable iff (!reset_n)
		1'b1 |-> (reg_image_q & ~store_mask) == '0;
	endproperty
	a_reserved_bits: assert property (p_reserved_bits) else $error("reserved bit stored");

	// Checked without a disable so the reset itself is covered
	property p_reset_clear;
		@(posedge clk) !reset_n |=> reg_image_q == '0 && !ack_q && !err_q && !skip_q &&
			rdata_q == 8'h00 && eeprom_sel_addr_q == 16'h0000;
	endproperty
	a_reset_clear: assert property (p_reset_clear) else $error("reset left state");

endmodule : iod_io_space_decoder
`default_nettype wire

// ==== iod_core_model.sv ====
// Processor core model that issues I/O, bit and load/store requests
`timescale 1ns/10ps
`default_nettype none
module iod_core_model (
	input  wire logic               clk,
	output var logic                req,
	output var iod_pkg::iod_op_type op,
	output var logic [7:0]          addr,
	output var logic [7:0]          wdata,
	output var logic [2:0]          bit_sel,
	input  wire logic               ack_q,
	input  wire logic               err_q,
	input  wire logic               skip_q,
	input  wire logic [7:0]         rdata_q
);
	logic [2:0] got;
	logic [7:0] got_rdata;
	initial begin
		req = 1'b0;
		op = iod_pkg::io_read_instr;
		addr = 8'h00;
		wdata = 8'h00;
		bit_sel = 3'h0;
	end
	// Reserved bits go out as zero except where the bench aims at them
	task automatic issue(input iod_pkg::iod_op_type o, input logic [7:0] a,
		input logic [7:0] d, input logic [2:0] b);
		@(negedge clk);
		req = 1'b1;
		op = o;
		addr = a;
		wdata = d;
		bit_sel = b;
		@(negedge clk);
		got = {ack_q, err_q, skip_q};
		got_rdata = rdata_q;
		req = 1'b0;
		// Released data is inverted so a stale value cannot pass for a fresh one
		wdata = ~d;
		addr = ~a;
	endtask : issue
endmodule : iod_core_model
`default_nettype wire

// ==== iod_io_space_decoder_test.sv ====
// Self-checking bench of the I/O register space decoder
`timescale 1ns/10ps
`default_nettype none
`include "iod_map.svh"
`define CHK(w, e, s) begin tests_run++; if ((s) !== (e)) begin \
	$display("BAD %s expected %h seen %h", w, e, s); fail_count++; end end
module iod_io_space_decoder_test;
	localparam int EE_TOP = 7;
	logic                      clk;
	logic                      reset_n;
	logic                      req;
	iod_pkg::iod_op_type       op;
	logic [7:0]                addr;
	logic [7:0]                wdata;
	logic [2:0]                bit_sel;
	logic [`IOD_IMAGE_W-1:0]   hw_set_flat;
	logic [`IOD_IMAGE_W-1:0]   hw_status_flat;
	logic                      ack_q;
	logic                      err_q;
	logic                      skip_q;
	logic [7:0]                rdata_q;
	logic [`IOD_IMAGE_W-1:0]   reg_image_q;
	logic [15:0]               eeprom_sel_addr_q;
	int                        fail_count = 0;
	int                        tests_run = 0;
	int                        cycles = 0;
	iod_io_space_decoder #(.EE_TOP_BIT(EE_TOP)) u_iod_io_space_decoder (.clk(clk),
		.reset_n(reset_n), .req(req), .op(op), .addr(addr), .wdata(wdata),
		.bit_sel(bit_sel), .hw_set_flat(hw_set_flat), .hw_status_flat(hw_status_flat),
		.ack_q(ack_q), .err_q(err_q), .skip_q(skip_q), .rdata_q(rdata_q),
		.reg_image_q(reg_image_q), .eeprom_sel_addr_q(eeprom_sel_addr_q));
	iod_core_model u_iod_core_model (.clk(clk), .req(req), .op(op), .addr(addr),
		.wdata(wdata), .bit_sel(bit_sel), .ack_q(ack_q), .err_q(err_q),
		.skip_q(skip_q), .rdata_q(rdata_q));
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	task automatic give_verdict();
		$display("Comparisons %0d, mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : give_verdict
	// Hangs are cut short well beyond the fewer than 100 cycles the run needs
	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			fail_count++;
			give_verdict();
		end
	end
	function automatic logic [7:0] img(input int a);
		return reg_image_q[(a - 32) * 8 +: 8];
	endfunction : img
	// One request with its answer flags {ack, err, skip} and read data judged
	task automatic ask(input iod_pkg::iod_op_type o, input logic [7:0] a,
		input logic [7:0] d, input logic [2:0] b, input logic [2:0] f, input logic [7:0] r);
		u_iod_core_model.issue(o, a, d, b);
		`CHK("flags", f, u_iod_core_model.got)
		`CHK("rdata", r, u_iod_core_model.got_rdata)
	endtask : ask
	task automatic t_alias();
		ask(iod_pkg::io_write_instr, 8'h01, 8'h5A, 3'h0, 3'h4, 8'h00);
		`CHK("port_a_direction", 8'h5A, img(8'h21))
		ask(iod_pkg::data_load_instrs, 8'h21, 8'h00, 3'h0, 3'h4, 8'h5A);
		ask(iod_pkg::io_read_instr, 8'h00, 8'h00, 3'h0, 3'h4, 8'hC3);
		ask(iod_pkg::io_write_instr, 8'h3F, 8'hA5, 3'h0, 3'h4, 8'h00);
		ask(iod_pkg::data_load_instrs, 8'h5F, 8'h00, 3'h0, 3'h4, 8'hA5);
	endtask : t_alias
	task automatic t_bits();
		ask(iod_pkg::io_bit_set_instr, 8'h02, 8'h00, 3'h3, 3'h4, 8'h00);
		ask(iod_pkg::io_bit_set_instr, 8'h02, 8'h00, 3'h0, 3'h4, 8'h00);
		ask(iod_pkg::io_bit_clear_instr, 8'h02, 8'h00, 3'h3, 3'h4, 8'h00);
		`CHK("port_a_output_latch", 8'h01, img(8'h22))
		ask(iod_pkg::skip_if_io_bit_set_instr, 8'h02, 8'h00, 3'h0, 3'h5, 8'h00);
		ask(iod_pkg::skip_if_io_bit_clear_instr, 8'h02, 8'h00, 3'h0, 3'h4, 8'h00);
		ask(iod_pkg::skip_if_io_bit_clear_instr, 8'h02, 8'h00, 3'h3, 3'h5, 8'h00);
		ask(iod_pkg::io_bit_set_instr, 8'h1F, 8'h00, 3'h5, 3'h4, 8'h00);
		`CHK("eeprom_control", 8'h20, img(8'h3F))
		ask(iod_pkg::io_bit_set_instr, 8'h20, 8'h00, 3'h0, 3'h6, 8'h00);
	endtask : t_bits
	task automatic t_w1c();
		@(negedge clk);
		hw_set_flat[21 * 8 +: 8] = 8'h03;
		@(negedge clk);
		hw_set_flat[21 * 8 +: 8] = 8'h00;
		`CHK("timer0_flags set", 8'h03, img(8'h35))
		ask(iod_pkg::io_write_instr, 8'h15, 8'h00, 3'h0, 3'h4, 8'h00);
		`CHK("timer0_flags zero", 8'h03, img(8'h35))
		ask(iod_pkg::io_bit_set_instr, 8'h15, 8'h00, 3'h1, 3'h4, 8'h00);
		`CHK("timer0_flags bit", 8'h01, img(8'h35))
		ask(iod_pkg::io_bit_clear_instr, 8'h15, 8'h00, 3'h0, 3'h4, 8'h00);
		`CHK("timer0_flags keep", 8'h01, img(8'h35))
		ask(iod_pkg::data_store_instrs, 8'h35, 8'h01, 3'h0, 3'h4, 8'h00);
		`CHK("timer0_flags one", 8'h00, img(8'h35))
		// A flag raised in the clearing cycle survives the clear
		hw_set_flat[21 * 8 +: 8] = 8'h01;
		ask(iod_pkg::data_store_instrs, 8'h35, 8'h01, 3'h0, 3'h4, 8'h00);
		hw_set_flat[21 * 8 +: 8] = 8'h00;
		`CHK("timer0_flags wins", 8'h01, img(8'h35))
	endtask : t_w1c
	task automatic t_refuse();
		ask(iod_pkg::data_store_instrs, 8'h60, 8'h05, 3'h0, 3'h4, 8'h00);
		ask(iod_pkg::data_load_instrs, 8'h60, 8'h00, 3'h0, 3'h4, 8'h05);
		ask(iod_pkg::io_write_instr, 8'h40, 8'hFF, 3'h0, 3'h6, 8'h00);
		`CHK("wdt kept", 8'h05, img(8'h60))
		ask(iod_pkg::io_read_instr, 8'h40, 8'h00, 3'h0, 3'h6, 8'h00);
		ask(iod_pkg::data_load_instrs, 8'h61, 8'h00, 3'h0, 3'h6, 8'h00);
		ask(iod_pkg::data_load_instrs, 8'h1F, 8'h00, 3'h0, 3'h6, 8'h00);
	endtask : t_refuse
	task automatic t_reserved();
		ask(iod_pkg::data_store_instrs, 8'h26, 8'hFF, 3'h0, 3'h4, 8'h00);
		ask(iod_pkg::data_load_instrs, 8'h26, 8'h00, 3'h0, 3'h4, 8'h00);
		`CHK("reserved", 8'h00, img(8'h26))
		ask(iod_pkg::data_store_instrs, 8'h3D, 8'hFF, 3'h0, 3'h4, 8'h00);
		ask(iod_pkg::data_load_instrs, 8'h3D, 8'h00, 3'h0, 3'h4, 8'h03);
	endtask : t_reserved
	task automatic t_eeprom();
		logic [15:0] exp;
		exp = 16'h01AB & ~(16'hFFFF << (EE_TOP + 1));
		ask(iod_pkg::data_store_instrs, 8'h42, 8'h01, 3'h0, 3'h4, 8'h00);
		ask(iod_pkg::data_store_instrs, 8'h41, 8'hAB, 3'h0, 3'h4, 8'h00);
		@(negedge clk);
		`CHK("ee addr", exp, eeprom_sel_addr_q)
	endtask : t_eeprom
	// Reset in mid-run must wipe stored state and the derived EEPROM address
	task automatic t_reset();
		@(negedge clk);
		reset_n = 1'b0;
		repeat (2) @(negedge clk);
		reset_n = 1'b1;
		`CHK("port_a_direction reset", 8'h00, img(8'h21))
		`CHK("ee reset", 16'h0000, eeprom_sel_addr_q)
		ask(iod_pkg::io_read_instr, 8'h1D, 8'h00, 3'h0, 3'h4, 8'h00);
	endtask : t_reset
	initial begin
		reset_n = 1'b0;
		hw_set_flat = '0;
		hw_status_flat = '0;
		hw_status_flat[7:0] = 8'hC3;
		repeat (8) @(negedge clk);
		reset_n = 1'b1;
		t_alias();
		t_bits();
		t_w1c();
		t_refuse();
		t_reserved();
		t_eeprom();
		t_reset();
		give_verdict();
	end
endmodule : iod_io_space_decoder_test
`default_nettype wire
